// *** inc/acp_map.svh ***
// Offsets, field positions, reset values and counts of the serial configuration port.
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// ----------------------------------------------------------------------------
// Register bus offsets
// ----------------------------------------------------------------------------
`define ACP_ADDR_CTRL 4'h0
`define ACP_ADDR_STATUS 4'h1
`define ACP_ADDR_ERROR 4'h2
`define ACP_ADDR_FRAMES 4'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACP_CTRL_ENABLE 0
`define ACP_ERR_UNDERRUN 0
`define ACP_ERR_SHORT 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ACP_CTRL_RESET 1'h1
`define ACP_CFG_RESET 12'h000
`define ACP_PINS_IDLE 3'h6

// ----------------------------------------------------------------------------
// Frame counts
// ----------------------------------------------------------------------------
`define ACP_CFG_EDGES 5'h0C
`define ACP_LAST_EDGE 5'h0F

`endif

// *** inc/acp_pkg.sv ***
// Types shared by the serial configuration port and its bench.
package acp_pkg;

  // --------------------------------------------------------------------------
  // Pin group sampled from the host
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } acp_pins_t;

  // --------------------------------------------------------------------------
  // Twelve-bit configuration word, top bit first on the wire
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic write_en;
    logic sequencer_ctl_hi;
    logic [1:0] spare_hi;
    logic channel_sel_hi;
    logic channel_sel_lo;
    logic power_mode_hi;
    logic power_mode_lo;
    logic sequencer_ctl_lo;
    logic spare_lo;
    logic range_sel;
    logic coding_sel;
  } acp_cfg_t;

  // --------------------------------------------------------------------------
  // Frame states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_SHIFT = 2'b01,
    ACP_DONE = 2'b10
  } acp_state_t;

endpackage

// *** hw/acp_fifo.sv ***
// Small synchronous FIFO with registered ready and valid flags.
`timescale 1ns/1ns
module acp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] next_level;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    next_level = o_level;
    if (push & ~pop) begin
      next_level = o_level + 1'b1;
    end else if (pop & ~push) begin
      next_level = o_level - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_level <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= step(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= step(rd_ptr);
      end
      o_level <= next_level;
      o_in_ready <= (next_level != CW'(DEPTH));
      o_out_valid <= (next_level != '0);
    end
  end

endmodule

// *** hw/acp_serial_port.sv ***
// Serial frame logic: configuration capture, result shift-out and control registers.
//
// Contract
// RULE1: The twelve-bit configuration register is write-only from the serial side and never readable.
// RULE2: Each configuration bit is captured from the serial input on a falling serial clock edge.
// RULE3: A configuration word shifted in during a frame applies to the following conversion.
// RULE4: A frame is sixteen serial clocks, and the host supplies all sixteen every frame.
// RULE5: Only the bits of the first twelve falling edges after chip select falls are used.
// RULE6: The first serial bit lands in the top bit of the configuration register.
// RULE7: The sampling stage returns to tracking when a conversion ends and tracks until the next sample.
// RULE8: A falling chip select samples the input, starts a conversion and opens the frame.
// RULE9: The serial output sends two zeros, two channel bits, then twelve result bits top bit first.
// RULE10: A twelve-bit word whose top bit is one is stored, otherwise the register is left unchanged.
// RULE11: The range bit picks the double span at zero and the coding bit picks twos complement at zero.
// RULE12: After the sixteenth clock further edges are ignored until chip select rises and falls again.
`timescale 1ns/1ns
`include "acp_map.svh"
module acp_serial_port
  import acp_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire acp_pins_t i_pins,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_conv_start,
  output logic o_track,
  output acp_cfg_t o_conv_cfg,
  input wire logic i_sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] i_sample_data,
  output logic o_sample_ready,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rd_data
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  acp_pins_t sync1;
  acp_pins_t sync2;
  acp_pins_t sync3;
  acp_pins_t lvl;
  acp_pins_t next_lvl;
  acp_state_t state;
  acp_state_t next_state;
  acp_cfg_t cfg;
  acp_cfg_t in_word;
  logic [10:0] in_shift;
  logic [14:0] out_shift;
  logic [4:0] edge_cnt;
  logic [15:0] frames;
  logic [1:0] err;
  logic enable;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic frame_start;
  logic shift_edge;
  logic last_edge;
  logic short_frame;
  logic underrun;
  logic fifo_valid;
  logic [SAMPLE_WIDTH-1:0] fifo_data;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
  logic [SAMPLE_WIDTH-1:0] coded;
  logic [15:0] next_rd_data;
  logic err_wr;

  // Selected output coding: straight binary, or the top bit turned over.
  function automatic logic [SAMPLE_WIDTH-1:0] apply_coding(
    input logic [SAMPLE_WIDTH-1:0] value,
    input logic straight
  );
    apply_coding = straight ? value : {~value[SAMPLE_WIDTH-1], value[SAMPLE_WIDTH-2:0]};
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and level filter
  // --------------------------------------------------------------------------
  // A pin level is taken only once the second and third stages agree.
  // The serial clock must stay well below a quarter of the system clock.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1 <= `ACP_PINS_IDLE;
      sync2 <= `ACP_PINS_IDLE;
      sync3 <= `ACP_PINS_IDLE;
    end else begin
      sync1 <= i_pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign next_lvl = (sync3 & ~(sync2 ^ sync3)) | (lvl & (sync2 ^ sync3));

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl <= `ACP_PINS_IDLE;
    end else begin
      lvl <= next_lvl;
    end
  end

  assign cs_fall = lvl.cs_n & ~next_lvl.cs_n;
  assign cs_rise = ~lvl.cs_n & next_lvl.cs_n;
  assign sclk_fall = lvl.sclk & ~next_lvl.sclk;

  // --------------------------------------------------------------------------
  // Frame sequencing
  // --------------------------------------------------------------------------
  assign frame_start = (state == ACP_IDLE) & cs_fall & enable; // RULE8
  assign shift_edge = (state == ACP_SHIFT) & sclk_fall & ~cs_rise; // RULE12
  assign last_edge = shift_edge & (edge_cnt == `ACP_LAST_EDGE); // RULE4
  assign short_frame = (state == ACP_SHIFT) & cs_rise;

  always_comb begin
    next_state = state;
    case (state)
      ACP_IDLE: begin
        if (frame_start) begin
          next_state = ACP_SHIFT;
        end
      end
      ACP_SHIFT: begin
        if (cs_rise) begin
          next_state = ACP_IDLE;
        end else if (last_edge) begin
          next_state = ACP_DONE; // RULE12
        end
      end
      ACP_DONE: begin
        if (cs_rise) begin
          next_state = ACP_IDLE; // RULE12
        end
      end
      default: begin
        next_state = ACP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ACP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_cnt <= '0;
    end else if (frame_start) begin
      edge_cnt <= '0;
    end else if (shift_edge) begin
      edge_cnt <= edge_cnt + 1'b1; // RULE4
    end
  end

  // --------------------------------------------------------------------------
  // Configuration capture
  // --------------------------------------------------------------------------
  assign in_word = {in_shift, lvl.din}; // RULE6

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_shift <= '0;
    end else if (shift_edge && edge_cnt < `ACP_CFG_EDGES) begin
      in_shift <= {in_shift[9:0], lvl.din}; // RULE2
    end
  end

  // The stored word has no read path; it steers later conversions and the coding and channel bits shifted out.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= `ACP_CFG_RESET; // RULE1
    end else if (shift_edge && edge_cnt == `ACP_CFG_EDGES - 5'h01) begin
      if (in_word.write_en) begin
        cfg <= in_word; // RULE10
      end
    end // RULE5
  end

  // The word seen by a conversion is frozen when its frame opens.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_conv_cfg <= `ACP_CFG_RESET;
    end else if (frame_start) begin
      o_conv_cfg <= cfg; // RULE3
    end
  end

  // --------------------------------------------------------------------------
  // Conversion start and track-and-hold
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= frame_start; // RULE8
    end
  end

  // An aborted frame also ends the conversion and returns to tracking.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_track <= 1'b1;
    end else if (frame_start) begin
      o_track <= 1'b0;
    end else if (last_edge || short_frame) begin
      o_track <= 1'b1; // RULE7
    end
  end

  // --------------------------------------------------------------------------
  // Result buffer and serial output
  // --------------------------------------------------------------------------
  acp_fifo #(
    .WIDTH(SAMPLE_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_sample_valid),
    .i_in_data(i_sample_data),
    .o_in_ready(o_sample_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(frame_start),
    .o_level(fifo_level)
  );

  assign underrun = frame_start & ~fifo_valid;
  assign coded = fifo_valid ? apply_coding(fifo_data, cfg.coding_sel) : '0; // RULE11

  // The first leading zero appears with chip select; each later bit on a falling edge.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_shift <= '0;
      o_dout <= 1'b0;
    end else if (frame_start) begin
      out_shift <= {1'b0, cfg.channel_sel_hi, cfg.channel_sel_lo, coded}; // RULE9
      o_dout <= 1'b0; // RULE9
    end else if (shift_edge && edge_cnt < `ACP_LAST_EDGE) begin
      o_dout <= out_shift[14]; // RULE9
      out_shift <= {out_shift[13:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dout_oe <= 1'b0;
    end else if (frame_start) begin
      o_dout_oe <= 1'b1;
    end else if (cs_rise) begin
      o_dout_oe <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control, error and frame count registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable <= `ACP_CTRL_RESET;
    end else if (i_wr && i_addr == `ACP_ADDR_CTRL) begin
      enable <= i_wr_data[`ACP_CTRL_ENABLE];
    end
  end

  assign err_wr = i_wr & (i_addr == `ACP_ADDR_ERROR);

  // Write one to clear; a new event in the same cycle keeps its bit set.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err <= '0;
    end else begin
      err[`ACP_ERR_UNDERRUN] <= (err[`ACP_ERR_UNDERRUN]
        & ~(err_wr & i_wr_data[`ACP_ERR_UNDERRUN])) | underrun;
      err[`ACP_ERR_SHORT] <= (err[`ACP_ERR_SHORT]
        & ~(err_wr & i_wr_data[`ACP_ERR_SHORT])) | short_frame; // RULE4
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frames <= '0;
    end else if (last_edge) begin
      frames <= frames + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_comb begin
    next_rd_data = '0;
    case (i_addr)
      `ACP_ADDR_CTRL: begin
        next_rd_data[`ACP_CTRL_ENABLE] = enable;
      end
      `ACP_ADDR_STATUS: begin
        next_rd_data = {10'h000, fifo_level, (state == ACP_DONE),
          (state != ACP_IDLE), o_track};
      end
      `ACP_ADDR_ERROR: begin
        next_rd_data = {14'h0000, err};
      end
      `ACP_ADDR_FRAMES: begin
        next_rd_data = frames;
      end
      default: begin
        next_rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= '0;
    end else if (i_rd) begin
      o_rd_data <= next_rd_data; // RULE1
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule

// *** tb/acp_serial_port_monitor.sv ***
// Port checker of the serial configuration port, bound to its top module.
`timescale 1ns/1ns
`include "acp_map.svh"
module acp_serial_port_monitor
  import acp_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire acp_pins_t i_pins,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_conv_start,
  input wire logic o_track,
  input wire acp_cfg_t o_conv_cfg,
  input wire logic i_sample_valid,
  input wire logic [SAMPLE_WIDTH-1:0] i_sample_data,
  input wire logic o_sample_ready,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rd_data
);
  // ------
  // Frame and register read checks
  // ------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_start;
    $rose(o_conv_start);
  endsequence
  sequence s_cs_released;
    $rose(i_pins.cs_n) ##1 i_pins.cs_n [*5];
  endsequence
  AST_START_BIT: assert property (s_start |-> o_dout_oe && !o_dout && !i_pins.cs_n)
    else $error("bad frame start");
  AST_START_PULSE: assert property (o_conv_start |=> !o_conv_start)
    else $error("start pulse too long");
  AST_START_HOLD: assert property (s_start |-> ##[0:2] !o_track)
    else $error("no hold after start");
  AST_TRACK_FALL: assert property (
    $fell(o_track) |-> o_conv_start || $past(o_conv_start))
    else $error("hold without start");
  AST_CFG_SNAP: assert property (
    $changed(o_conv_cfg) |-> o_conv_start || $past(o_conv_start))
    else $error("config moved mid frame");
  AST_CS_END: assert property (s_cs_released |=> o_track && !o_dout_oe)
    else $error("frame kept after release");
  AST_DOUT_EDGE: assert property (
    $changed(o_dout) |-> o_conv_start || !o_dout_oe || !i_pins.sclk)
    else $error("output bit moved off edge");
  AST_RD_UNMAPPED: assert property (
    i_rd && i_addr > `ACP_ADDR_FRAMES |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_IDLE: assert property (!i_rd |=> o_rd_data == 16'h0000)
    else $error("read data without read");
endmodule

bind acp_serial_port acp_serial_port_monitor #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) mon_u (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(i_pins), .o_dout(o_dout),
  .o_dout_oe(o_dout_oe), .o_conv_start(o_conv_start), .o_track(o_track),
  .o_conv_cfg(o_conv_cfg), .i_sample_valid(i_sample_valid), .i_sample_data(i_sample_data),
  .o_sample_ready(o_sample_ready), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
  .i_rd(i_rd), .o_rd_data(o_rd_data)
);

// *** tb/acp_host_model.sv ***
// Behavioural host serial master that frames transfers on the pins.
`timescale 1ns/1ns
`include "acp_map.svh"
module acp_host_model
  import acp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_dout,
  output acp_pins_t o_pins
);
  initial o_pins = acp_pins_t'(`ACP_PINS_IDLE);

  // ------
  // One frame of nf falls, ph cycles per clock phase
  // ------
  task automatic frame(input logic [11:0] w, input int ph, input int nf,
                       output logic [15:0] got);
    got = 16'h0000;
    o_pins.cs_n <= 1'b0;
    for (int i = 0; i < nf; i++) begin
      o_pins.din <= (i < 12) ? w[11 - i] : w[i - 12];
      repeat (ph) @(posedge i_clock);
      if (i < 16) got[15 - i] = i_dout;
      o_pins.sclk <= 1'b0;
      repeat (ph) @(posedge i_clock);
      o_pins.sclk <= 1'b1;
    end
    repeat (ph) @(posedge i_clock);
    o_pins.cs_n <= 1'b1;
    o_pins.din <= ~o_pins.din;
    repeat (8) @(posedge i_clock);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the serial configuration port.
`timescale 1ns/1ns
`include "acp_map.svh"
module testbench
  import acp_pkg::*;
();
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  acp_pins_t pins;
  acp_cfg_t ccfg, cur;
  logic dout, oe, cst, trk, sv, srdy, wr, rd, en;
  logic rd_q = 1'b0;
  logic [11:0] sd;
  logic [3:0] addr;
  logic [15:0] wdat, rdat, lf;
  logic [15:0] exp_q[$];
  logic [11:0] samp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 i_clock = ~i_clock;

  acp_serial_port dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(pins), .o_dout(dout), .o_dout_oe(oe),
    .o_conv_start(cst), .o_track(trk), .o_conv_cfg(ccfg), .i_sample_valid(sv),
    .i_sample_data(sd), .o_sample_ready(srdy), .i_addr(addr), .i_wr_data(wdat),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdat)
  );
  acp_host_model host_u (.i_clock(i_clock), .i_dout(dout), .o_pins(pins));

  // ------
  // Helpers
  // ------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    @(posedge i_clock);
  endtask

  // Offers seven words; only those taken while ready was high are kept.
  task automatic fill();
    repeat (7) begin
      lf = lfsr(lf);
      sd <= lf[11:0];
      sv <= 1'b1;
      @(posedge i_clock);
      if (srdy === 1'b1) samp_q.push_back(sd);
    end
    sv <= 1'b0;
  endtask

  task automatic frame(input logic [11:0] w, input int ph, input int nf);
    logic [15:0] got;
    logic [11:0] r;
    acp_cfg_t c0;
    c0 = cur;
    if (en) begin
      // An empty buffer at frame start sends an all-zero result.
      if (samp_q.size() > 0) begin
        r = samp_q.pop_front();
        r[11] = r[11] ^ ~cur.coding_sel;
      end else begin
        r = 12'h000;
      end
      if (nf >= 16) exp_q.push_back({2'b00, cur.channel_sel_hi, cur.channel_sel_lo, r});
    end
    host_u.frame(w, ph, nf, got);
    if (en && nf >= 16) chk("dout", got, exp_q.pop_front());
    if (en) chk("conv_cfg", {4'h0, ccfg}, {4'h0, c0});
    if (en && nf >= 12 && w[11]) cur = w;
  endtask

  always @(posedge i_clock) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) chk("rd_data", rdat, exp_q.pop_front());
    if (cyc > 20000) begin
      fails++;
      end_sim();
    end
  end

  // ------
  // Main sequence
  // ------
  initial begin
    sv = 1'b0;
    sd = 12'h000;
    addr = 4'h0;
    wdat = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    en = 1'b1;
    lf = 16'h8208;
    cur = acp_cfg_t'(12'h000);
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clock);
    rd_reg(`ACP_ADDR_CTRL, 16'h0001);
    rd_reg(`ACP_ADDR_ERROR, 16'h0000);
    rd_reg(4'hF, 16'h0000);
    fill();
    chk("fifo_words", 16'(samp_q.size()), 16'h0004);
    rd_reg(`ACP_ADDR_STATUS, 16'h0021);
    frame(12'h7FF, 7, 16);
    lf = lfsr(lf);
    frame({1'b1, lf[10:0]}, 12, 18);
    lf = lfsr(lf);
    frame({1'b1, lf[10:0]}, 7, 8);
    rd_reg(`ACP_ADDR_ERROR, 16'h0002);
    wr_reg(`ACP_ADDR_ERROR, 16'h0002);
    rd_reg(`ACP_ADDR_ERROR, 16'h0000);
    lf = lfsr(lf);
    frame({1'b1, lf[10:0]}, 8, 16);
    rd_reg(`ACP_ADDR_STATUS, 16'h0001);
    rd_reg(`ACP_ADDR_FRAMES, 16'h0003);
    wr_reg(`ACP_ADDR_CTRL, 16'h0000);
    en = 1'b0;
    frame(12'hFFF, 7, 16);
    rd_reg(`ACP_ADDR_FRAMES, 16'h0003);
    wr_reg(`ACP_ADDR_CTRL, 16'h0001);
    en = 1'b1;
    lf = lfsr(lf);
    frame({1'b1, lf[10:0]}, 7, 16);
    rd_reg(`ACP_ADDR_ERROR, 16'h0001);
    wr_reg(`ACP_ADDR_ERROR, 16'h0001);
    rd_reg(`ACP_ADDR_ERROR, 16'h0000);
    fill();
    frame(12'h000, 7, 16);
    repeat (3) @(posedge i_clock);
    end_sim();
  end
endmodule
